/* rtl/spr_pkg.sv */
/*
  Package for the system loop configuration and status register bank.
  Holds byte offsets, reset values, state codes and feedback select codes.
  Assumes an 8-bit byte-addressed configuration port in front of the bank.
*/
package spr_pkg;

  // ------------------------------------------------------------
  // Byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] SPR_OFS_INT = 8'h23;
  localparam logic [7:0] SPR_OFS_NUM_LO = 8'h24;
  localparam logic [7:0] SPR_OFS_NUM_HI = 8'h25;
  localparam logic [7:0] SPR_OFS_DEN_LO = 8'h28;
  localparam logic [7:0] SPR_OFS_DEN_HI = 8'h29;
  localparam logic [7:0] SPR_OFS_FB_REQ = 8'h44;
  localparam logic [7:0] SPR_OFS_LOCK = 8'h46;
  localparam logic [7:0] SPR_OFS_FILT_LO = 8'h47;
  localparam logic [7:0] SPR_OFS_FILT_HI = 8'h4c;
  localparam logic [7:0] SPR_OFS_PHASE_LO = 8'h4d;
  localparam logic [7:0] SPR_OFS_PHASE_HI = 8'h51;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] SPR_RST_INT = 8'h24;
  localparam logic [15:0] SPR_RST_NUM = 16'h0000;
  localparam logic [15:0] SPR_RST_DEN = 16'h8000;
  localparam logic [15:0] SPR_RST_LOCK_LIMIT = 16'h0115;
  localparam logic [7:0] SPR_RST_LOCK_TIMER = 8'h0a;

  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int SPR_FB_SEL_POS = 6;
  localparam int SPR_LOCK_POS = 3;
  localparam logic [2:0] SPR_ST_FREE = 3'h0;
  localparam logic [2:0] SPR_ST_ACQ = 3'h1;
  localparam logic [2:0] SPR_ST_LOCK = 3'h2;
  localparam logic [2:0] SPR_ST_HOLD = 3'h3;
  localparam logic [2:0] SPR_ST_RECOV = 3'h4;
  localparam logic [2:0] SPR_ST_AUTO = 3'h5;
  localparam logic [1:0] SPR_FB_REF0 = 2'h1;
  localparam logic [1:0] SPR_FB_REF1 = 2'h2;
  localparam logic [1:0] SPR_FBR_OWN = 2'h0;
  localparam logic [1:0] SPR_FBR_REF0 = 2'h1;
  localparam logic [1:0] SPR_FBR_REF1 = 2'h2;

  // Lock qualify tick: one timer step is 256 loop updates.
  localparam int SPR_TIMER_UNIT = 256;

endpackage : spr_pkg

/* rtl/spr_regs.sv */
/*
  Register bank for the system analog loop divider and the system digital
  loop control and status, with a lock qualifier.
  Assumes a one-cycle byte read/write strobe from the serial port decoder
  and live loop values sampled on the same clock.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - Analog loop divider integer, 8 bits, read/write, resets to 0x24.
// - Divider numerator, 16 bits over two bytes, read/write, resets to zero.
// - Divider denominator, 16 bits over two bytes, read/write, resets to 0x8000.
// - Feedback select: 00/11 own feedback, 01 reference zero, 10 reference one.
// - State request 000 free-run to 101 automatic, defaults to 000.
// - Read-only lock flag, 1 locked, 0 unlocked, resets to 0.
// - Read-only current state with the same codes, resets to 000.
// - Read-only 48-bit loop filter word over six bytes, resets to zero.
// - Read-only 36-bit phase detector word over five bytes, resets to zero.
// - Loop reset control high holds monitors and loops in reset.
// - Lock declared only after phase error stays within limit for timer period.
module spr_regs #(
  parameter int UPDATE_DIV = 192
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic loop_reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [47:0] loop_filter_live,
  input wire logic [35:0] phase_error_live,
  input wire logic [2:0] loop_state_live,
  input wire logic [15:0] lock_phase_limit,
  input wire logic [7:0] lock_qualify_period,
  output logic [7:0] apll_divider_integer,
  output logic [15:0] apll_divider_numerator,
  output logic [15:0] apll_divider_denominator,
  output logic [1:0] phase_detector_feedback_select,
  output logic [2:0] loop_state_request,
  output logic loop_block_reset
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] int_q, int_d;
  logic [15:0] num_q, num_d, den_q, den_d;
  logic [1:0] fb_q, fb_d;
  logic [2:0] req_q, req_d, st_q, st_d;
  logic lock_q, lock_d;
  logic [47:0] filt_q, filt_d;
  logic [35:0] ph_q, ph_d;
  logic [15:0] tick_q, tick_d;
  logic [15:0] qual_q, qual_d;
  logic [7:0] rd_q, rd_d;
  logic [35:0] ph_abs;
  logic in_limit;
  logic clr;

  // Magnitude of the signed phase error, compared against the unsigned limit.
  assign ph_abs = phase_error_live[35] ? 36'(-phase_error_live) : phase_error_live;
  assign in_limit = ph_abs <= {20'h00000, lock_phase_limit};
  assign clr = reset | loop_reset;
  assign loop_block_reset = loop_reset;

  // Byte lane of a snapshot word; base is the lowest byte offset.
  function automatic logic [7:0] spr_byte(input logic [47:0] w, input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] idx;
    idx = a - base;
    spr_byte = w[idx[2:0]*8 +: 8];
  endfunction : spr_byte

  // Next values: writes, snapshots, lock qualifier and read data.
  always_comb begin
    int_d = int_q;
    num_d = num_q;
    den_d = den_q;
    fb_d = fb_q;
    req_d = req_q;
    filt_d = filt_q;
    ph_d = ph_q;
    st_d = loop_state_live;
    tick_d = tick_q + 16'h0001;
    qual_d = qual_q;
    lock_d = lock_q;
    rd_d = 8'h00;
    // Lock qualifier: restart the period whenever the error leaves the window.
    if (!in_limit) begin
      qual_d = 16'h0000;
      lock_d = 1'b0;
    end else if (tick_q == 16'(UPDATE_DIV - 1)) begin
      if (qual_q >= 16'(lock_qualify_period) * 16'(spr_pkg::SPR_TIMER_UNIT)) begin
        lock_d = 1'b1;
      end else begin
        qual_d = qual_q + 16'h0001;
      end
    end
    if (tick_q == 16'(UPDATE_DIV - 1)) begin
      tick_d = 16'h0000;
    end
    if (wr_en) begin
      if (addr == spr_pkg::SPR_OFS_INT) begin
        int_d = wr_data;
      end else if (addr == spr_pkg::SPR_OFS_NUM_LO) begin
        num_d[7:0] = wr_data;
      end else if (addr == spr_pkg::SPR_OFS_NUM_HI) begin
        num_d[15:8] = wr_data;
      end else if (addr == spr_pkg::SPR_OFS_DEN_LO) begin
        den_d[7:0] = wr_data;
      end else if (addr == spr_pkg::SPR_OFS_DEN_HI) begin
        den_d[15:8] = wr_data;
      end else if (addr == spr_pkg::SPR_OFS_FB_REQ) begin
        fb_d = wr_data[7:6];
        req_d = wr_data[2:0];
      end
    end
    if (rd_en) begin
      if (addr == spr_pkg::SPR_OFS_INT) begin
        rd_d = int_q;
      end else if (addr == spr_pkg::SPR_OFS_NUM_LO) begin
        rd_d = num_q[7:0];
      end else if (addr == spr_pkg::SPR_OFS_NUM_HI) begin
        rd_d = num_q[15:8];
      end else if (addr == spr_pkg::SPR_OFS_DEN_LO) begin
        rd_d = den_q[7:0];
      end else if (addr == spr_pkg::SPR_OFS_DEN_HI) begin
        rd_d = den_q[15:8];
      end else if (addr == spr_pkg::SPR_OFS_FB_REQ) begin
        rd_d = {fb_q, 3'h0, req_q};
      end else if (addr == spr_pkg::SPR_OFS_LOCK) begin
        rd_d = {4'h0, lock_q, st_q};
      end else if (addr == spr_pkg::SPR_OFS_FILT_LO) begin
        filt_d = loop_filter_live;
        rd_d = loop_filter_live[7:0];
      end else if (addr > spr_pkg::SPR_OFS_FILT_LO && addr <= spr_pkg::SPR_OFS_FILT_HI) begin
        rd_d = spr_byte(filt_q, addr, spr_pkg::SPR_OFS_FILT_LO);
      end else if (addr == spr_pkg::SPR_OFS_PHASE_LO) begin
        ph_d = phase_error_live;
        rd_d = phase_error_live[7:0];
      end else if (addr > spr_pkg::SPR_OFS_PHASE_LO && addr <= spr_pkg::SPR_OFS_PHASE_HI) begin
        rd_d = spr_byte({12'h000, ph_q}, addr, spr_pkg::SPR_OFS_PHASE_LO);
      end
    end
  end

  // Register stage; the loop reset clears only the loop-side status.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      int_q <= spr_pkg::SPR_RST_INT;
      num_q <= spr_pkg::SPR_RST_NUM;
      den_q <= spr_pkg::SPR_RST_DEN;
      fb_q <= 2'h0;
      req_q <= spr_pkg::SPR_ST_FREE;
      rd_q <= 8'h00;
    end else begin
      int_q <= int_d;
      num_q <= num_d;
      den_q <= den_d;
      fb_q <= fb_d;
      req_q <= req_d;
      rd_q <= rd_d;
    end
    if (clr) begin
      lock_q <= 1'b0;
      st_q <= spr_pkg::SPR_ST_FREE;
      filt_q <= 48'h0;
      ph_q <= 36'h0;
      tick_q <= 16'h0000;
      qual_q <= 16'h0000;
    end else begin
      lock_q <= lock_d;
      st_q <= st_d;
      filt_q <= filt_d;
      ph_q <= ph_d;
      tick_q <= tick_d;
      qual_q <= qual_d;
    end
  end

  // Outputs to the loop; undefined requests fold onto automatic control.
  always_comb begin
    rd_data = rd_q;
    apll_divider_integer = int_q;
    apll_divider_numerator = num_q;
    apll_divider_denominator = den_q;
    phase_detector_feedback_select = (fb_q == 2'h3) ? spr_pkg::SPR_FBR_OWN : fb_q;
    loop_state_request = (req_q > spr_pkg::SPR_ST_AUTO) ? spr_pkg::SPR_ST_AUTO : req_q;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  lock_needs_window_a: assert property (@(posedge sys_clk) disable iff (clr)
    !in_limit |=> !lock_q) else $error("lock held while phase out of window");
  req_fold_a: assert property (@(posedge sys_clk) disable iff (reset)
    req_q[2:1] == 2'b11 |-> loop_state_request == 3'h5) else $error("bad request");
  fb_own_a: assert property (@(posedge sys_clk) disable iff (reset)
    fb_q == 2'h3 |-> phase_detector_feedback_select == 2'h0) else $error("fb fold");
  int_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_en && addr == 8'h23 |=> int_q == $past(wr_data)) else $error("int write");
  den_reset_a: assert property (@(posedge sys_clk)
    reset |=> den_q == 16'h8000 && num_q == 16'h0) else $error("den reset");
  loop_clear_a: assert property (@(posedge sys_clk)
    loop_reset |=> !lock_q && filt_q == 48'h0 && ph_q == 36'h0) else $error("clr");
  snap_hold_a: assert property (@(posedge sys_clk) disable iff (clr)
    !(rd_en && addr == 8'h47) |=> filt_q == $past(filt_q)) else $error("snap");
  lock_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == 8'h46 |=> rd_data == {4'h0, $past(lock_q), $past(st_q)})
    else $error("lock read");

endmodule : spr_regs

/* verification/spr_regs_bench.sv */
/*
  Self-checking bench for the loop configuration and status register bank.
  Assumes the one-cycle strobe port and the package constants of the design.
*/
`timescale 1ns/100ps
module spr_regs_bench;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic loop_reset = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [47:0] loop_filter_live = 48'hfedcba987654;
  logic [35:0] phase_error_live = 36'h987654321;
  logic [2:0] loop_state_live = 3'h4;
  logic [15:0] lock_phase_limit = 16'h0005;
  logic [7:0] lock_qualify_period = 8'h01;
  logic [7:0] rd_data, api, rb;
  logic [15:0] apn, apd;
  logic [1:0] fbs;
  logic [2:0] lsr;
  logic lbr;
  int miscompares = 0;
  int tests_run = 0;
  int i;

  // A short update divider keeps the lock qualify period at 512 cycles.
  spr_regs #(.UPDATE_DIV(2)) uut (.sys_clk(sys_clk), .reset(reset), .loop_reset(loop_reset),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .loop_filter_live(loop_filter_live), .phase_error_live(phase_error_live),
    .loop_state_live(loop_state_live), .lock_phase_limit(lock_phase_limit),
    .lock_qualify_period(lock_qualify_period), .apll_divider_integer(api),
    .apll_divider_numerator(apn), .apll_divider_denominator(apd),
    .phase_detector_feedback_select(fbs), .loop_state_request(lsr), .loop_block_reset(lbr));

  always #4 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    // Let the register update settle before any output is compared.
    #1;
  endtask : wr

  // Read data is registered, so it is taken just after the strobe edge.
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 rb = rd_data;
    chk({8'h00, rb}, {8'h00, exp});
  endtask : rchk

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // The whole sequence needs about 1900 cycles; this leaves wide margin.
  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(8'h23, 8'h24);
    rchk(8'h24, 8'h00);
    rchk(8'h29, 8'h80);
    rchk(8'h44, 8'h00);
    chk({fbs, 11'h0, lsr}, 16'h0);
    $display("reset values done");
    wr(8'h23, 8'h30);
    wr(8'h24, 8'h5a);
    wr(8'h25, 8'ha5);
    wr(8'h28, 8'h01);
    wr(8'h29, 8'h7f);
    chk({8'h00, api}, 16'h0030);
    chk(apn, 16'ha55a);
    chk(apd, 16'h7f01);
    rchk(8'h25, 8'ha5);
    wr(8'h46, 8'hff);
    wr(8'h30, 8'hff);
    rchk(8'h30, 8'h00);
    $display("divider access done");
    // Every select and request code, including the undefined ones.
    for (i = 0; i < 8; i++) begin
      wr(8'h44, {i[1:0], 3'h0, i[2:0]});
      chk({14'h0, fbs}, (i[1:0] == 2'h3) ? 16'h0 : {14'h0, i[1:0]});
      chk({13'h0, lsr}, (i >= 6) ? 16'h5 : {13'h0, i[2:0]});
    end
    $display("codes done");
    // Higher bytes must keep the value caught at the lowest byte.
    rchk(8'h47, 8'h54);
    loop_filter_live <= 48'h0;
    for (i = 1; i < 6; i++) rchk(8'h47 + i[7:0], 8'h54 + 8'h22 * i[7:0]);
    rchk(8'h4d, 8'h21);
    phase_error_live <= 36'h100;
    rchk(8'h50, 8'h87);
    rchk(8'h51, 8'h09);
    $display("snapshots done");
    // A negative error within the limit qualifies lock after 512 cycles.
    rchk(8'h46, 8'h04);
    phase_error_live <= 36'hffffffffd;
    repeat (300) @(posedge sys_clk);
    rchk(8'h46, 8'h04);
    repeat (300) @(posedge sys_clk);
    rchk(8'h46, 8'h0c);
    phase_error_live <= 36'h6;
    rchk(8'h46, 8'h04);
    phase_error_live <= 36'h0;
    repeat (600) @(posedge sys_clk);
    rchk(8'h46, 8'h0c);
    loop_reset <= 1'b1;
    @(posedge sys_clk);
    #1 chk({15'h0, lbr}, 16'h1);
    rchk(8'h46, 8'h00);
    loop_reset <= 1'b0;
    repeat (300) @(posedge sys_clk);
    rchk(8'h46, 8'h04);
    repeat (300) @(posedge sys_clk);
    rchk(8'h46, 8'h0c);
    // The limit is inclusive on both signs of the error.
    phase_error_live <= 36'h5;
    rchk(8'h46, 8'h0c);
    phase_error_live <= 36'hffffffffb;
    rchk(8'h46, 8'h0c);
    // A zero qualify period declares lock at the first update in window.
    loop_reset <= 1'b1;
    @(posedge sys_clk);
    loop_reset <= 1'b0;
    lock_qualify_period <= 8'h00;
    repeat (4) @(posedge sys_clk);
    rchk(8'h46, 8'h0c);
    $display("lock done");
    final_report();
  end
endmodule : spr_regs_bench
